// File: src/seq_phase_map.svh
// timing counts, strap decode figures and frame layout for the sequencing block
`ifndef SEQ_PHASE_MAP_SVH
`define SEQ_PHASE_MAP_SVH
`define CLK_MHZ 40
`define ADDR_MULT 10'h019
`define ADDR_W 7
`define PHASE_STEPS_PER_ADDR 2
`define PHASE_FULL_STEP 5'h10
`define SW_PERIOD_CYC 8'hA0
`define PHASE_SLOT_CYC 8'h0A
`define BIT_TIME_NS 2000
`define BIT_CYC ((`BIT_TIME_NS * `CLK_MHZ + 999) / 1000)
`define FRAME_BITS 4'hA
`define RX_DATA_BITS 4'h8
`define ROLES_PER_SYNC 3
`endif

// File: src/seq_phase_pkg.sv
// types for the sequencing and phase spreading block
package seq_phase_pkg;
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_WAIT_UP = 3'b001,
		ST_RAMP_UP = 3'b010,
		ST_ON = 3'b011,
		ST_WAIT_DN = 3'b100,
		ST_RAMP_DN = 3'b101
	} seq_state_t;
	typedef enum logic [1:0] {
		ROLE_DISABLED = 2'b00,
		ROLE_FIRST = 2'b01,
		ROLE_LAST = 2'b10,
		ROLE_MIDDLE = 2'b11
	} seq_role_t;
	typedef enum logic [1:0] {
		SYNC_INPUT = 2'b00,
		SYNC_AUTO = 2'b01,
		SYNC_OUTPUT = 2'b10
	} sync_dir_t;
endpackage

// File: src/seq_phase_spread.sv
// strap address decode, phase spreading and interdevice bus sequencing
`timescale 1ns/1ps
`include "seq_phase_map.svh"
module seq_phase_spread (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [4:0] addr_strap_low,
	input wire logic [4:0] addr_strap_high,
	input wire logic [3:0] cfg_strap,
	input wire logic current_share_en,
	input wire logic host_phase_en,
	input wire logic [4:0] host_phase_step,
	input wire logic host_chain_en,
	input wire logic host_pred_en,
	input wire logic [6:0] host_pred_addr,
	input wire logic host_succ_en,
	input wire logic [6:0] host_succ_addr,
	input wire logic group_enable,
	input wire logic power_good,
	input wire logic sync_in,
	input wire logic interdevice_bus_in,
	output logic interdevice_bus_out,
	output logic interdevice_bus_oe_b,
	output logic sync_out,
	output logic sync_out_oe_b,
	output logic sw_start,
	output logic rail_on,
	output logic [6:0] dev_addr,
	output logic [3:0] phase_step,
	output seq_phase_pkg::seq_role_t seq_role,
	output seq_phase_pkg::sync_dir_t sync_dir,
	output logic seq_active
);
	import seq_phase_pkg::*;

	localparam logic [7:0] BIT_CYC = 8'(`BIT_CYC);
	localparam logic [7:0] HALF_BIT = 8'(`BIT_CYC / 2);

	function automatic logic frame_hit(input logic [6:0] a, input logic d, input logic [6:0] t, input logic w);
		frame_hit = (a == t) && (d == w);
	endfunction

	seq_state_t state_reg, state_next;
	logic [6:0] addr_reg;
	logic [3:0] phase_reg;
	seq_role_t role_reg;
	sync_dir_t sdir_reg;
	logic [7:0] sw_cnt_reg;
	logic sw_start_reg, sync_out_reg, sync_oe_b_reg, sync_in_d_reg, sync_seen_reg;
	logic [7:0] tx_cnt_reg;
	logic [3:0] tx_left_reg;
	logic [9:0] tx_shift_reg;
	logic [7:0] rx_cnt_reg;
	logic [3:0] rx_left_reg;
	logic [7:0] rx_shift_reg;
	logic rx_busy_reg, rx_done_reg, up_seen_reg, dn_seen_reg, rail_reg, oe_b_reg;

	// address from the two strap indices, wrapped to seven bits
	wire [9:0] addr_full = addr_strap_high * `ADDR_MULT + {5'h00, addr_strap_low};
	wire [6:0] addr_next = addr_full[6:0];
	wire [1:0] cfg_role = 2'(cfg_strap / `ROLES_PER_SYNC);
	wire [1:0] cfg_sync = 2'(cfg_strap % `ROLES_PER_SYNC);
	wire cfg_valid = cfg_strap < 4'hC;
	wire auto_seq = (role_reg != ROLE_DISABLED) && !current_share_en && !host_chain_en;
	wire seq_on = auto_seq || host_chain_en;
	wire host_step_ok = host_phase_en && !auto_seq && (host_phase_step <= `PHASE_FULL_STEP);
	wire [3:0] addr_step = {addr_reg[2:0], 1'b0};
	wire [3:0] phase_next = host_step_ok ? host_phase_step[3:0] : addr_step;
	wire has_pred = host_chain_en ? host_pred_en : (role_reg == ROLE_LAST || role_reg == ROLE_MIDDLE);
	wire has_succ = host_chain_en ? host_succ_en : (role_reg == ROLE_FIRST || role_reg == ROLE_MIDDLE);
	wire [6:0] pred_addr = host_chain_en ? host_pred_addr : addr_reg - 7'h01;
	wire [6:0] succ_addr = host_chain_en ? host_succ_addr : addr_reg + 7'h01;
	wire rx_hit_up = rx_done_reg && frame_hit(rx_shift_reg[6:0], rx_shift_reg[7], pred_addr, 1'b1);
	wire rx_hit_dn = rx_done_reg && frame_hit(rx_shift_reg[6:0], rx_shift_reg[7], succ_addr, 1'b0);
	wire may_up = !has_pred || up_seen_reg || rx_hit_up;
	wire may_dn = !has_succ || dn_seen_reg || rx_hit_dn;
	wire tx_busy = tx_left_reg != 4'h0;
	wire send_up = seq_on && state_reg == ST_RAMP_UP && power_good && !tx_busy;
	wire send_dn = seq_on && state_reg == ST_RAMP_DN && !power_good && !tx_busy;
	wire rx_start = !rx_busy_reg && !tx_busy && !interdevice_bus_in;
	wire sync_edge = sync_in && !sync_in_d_reg;
	wire follow_sync = sdir_reg == SYNC_INPUT || (sdir_reg == SYNC_AUTO && sync_seen_reg);
	// eight bits wide so that step 15 still lands on cycle 150 of the period
	wire [7:0] phase_at = 8'(phase_reg) * `PHASE_SLOT_CYC;
	wire [7:0] sw_cnt_next = (follow_sync && sync_edge) || sw_cnt_reg == `SW_PERIOD_CYC - 8'h01 ? 8'h00
		: sw_cnt_reg + 8'h01;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_OFF: begin
				if (group_enable) begin
					state_next = ST_WAIT_UP;
				end
			end
			ST_WAIT_UP: begin
				if (!group_enable) begin
					state_next = ST_OFF;
				end else if (!seq_on || may_up) begin
					state_next = ST_RAMP_UP;
				end
			end
			ST_RAMP_UP: begin
				if (!group_enable) begin
					state_next = ST_WAIT_DN;
				end else if (power_good && (!seq_on || !tx_busy)) begin
					state_next = ST_ON;
				end
			end
			ST_ON: begin
				if (!group_enable) begin
					state_next = ST_WAIT_DN;
				end
			end
			ST_WAIT_DN: begin
				if (!seq_on || may_dn) begin
					state_next = ST_RAMP_DN;
				end
			end
			ST_RAMP_DN: begin
				if (!power_good && (!seq_on || !tx_busy)) begin
					state_next = ST_OFF;
				end
			end
			default: begin
				state_next = ST_OFF;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_reg <= ST_OFF;
			rail_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			rail_reg <= state_next == ST_RAMP_UP || state_next == ST_ON || state_next == ST_WAIT_DN;
		end
	end

	// strap decode, refreshed every cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			addr_reg <= 7'h00;
			role_reg <= ROLE_DISABLED;
			sdir_reg <= SYNC_INPUT;
			phase_reg <= 4'h0;
		end else begin
			addr_reg <= addr_next;
			role_reg <= cfg_valid ? seq_role_t'(cfg_role) : ROLE_DISABLED;
			sdir_reg <= cfg_valid ? sync_dir_t'(cfg_sync) : SYNC_INPUT;
			phase_reg <= phase_next;
		end
	end

	// switching period and phase-delayed cycle start
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			sw_cnt_reg <= 8'h00;
			sw_start_reg <= 1'b0;
			sync_in_d_reg <= 1'b0;
			sync_seen_reg <= 1'b0;
			sync_out_reg <= 1'b0;
			sync_oe_b_reg <= 1'b1;
		end else begin
			sw_cnt_reg <= sw_cnt_next;
			sw_start_reg <= sw_cnt_next == phase_at;
			sync_in_d_reg <= sync_in;
			sync_seen_reg <= sync_seen_reg || (sdir_reg == SYNC_AUTO && sync_edge);
			sync_out_reg <= sw_cnt_next == 8'h00;
			sync_oe_b_reg <= follow_sync;
		end
	end

	// event frame out: start bit, address, direction, stop
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			tx_cnt_reg <= 8'h00;
			tx_left_reg <= 4'h0;
			tx_shift_reg <= 10'h3FF;
			oe_b_reg <= 1'b1;
		end else if (send_up || send_dn) begin
			tx_shift_reg <= {1'b1, send_up, addr_reg, 1'b0};
			tx_left_reg <= `FRAME_BITS;
			tx_cnt_reg <= BIT_CYC - 8'h01;
			oe_b_reg <= 1'b0;
		end else if (tx_busy) begin
			if (tx_cnt_reg == 8'h00) begin
				tx_cnt_reg <= BIT_CYC - 8'h01;
				tx_left_reg <= tx_left_reg - 4'h1;
				tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
				oe_b_reg <= tx_left_reg == 4'h1 ? 1'b1 : tx_shift_reg[1];
			end else begin
				tx_cnt_reg <= tx_cnt_reg - 8'h01;
			end
		end else begin
			oe_b_reg <= 1'b1;
		end
	end

	// event frame in: sample mid-bit after the start bit
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rx_busy_reg <= 1'b0;
			rx_cnt_reg <= 8'h00;
			rx_left_reg <= 4'h0;
			rx_shift_reg <= 8'h00;
			rx_done_reg <= 1'b0;
		end else begin
			rx_done_reg <= 1'b0;
			if (rx_start) begin
				rx_busy_reg <= 1'b1;
				rx_cnt_reg <= BIT_CYC + HALF_BIT - 8'h01;
				rx_left_reg <= `RX_DATA_BITS;
			end else if (rx_busy_reg) begin
				if (rx_cnt_reg != 8'h00) begin
					rx_cnt_reg <= rx_cnt_reg - 8'h01;
				end else if (rx_left_reg == 4'h0) begin
					rx_busy_reg <= !interdevice_bus_in;
				end else begin
					rx_shift_reg <= {interdevice_bus_in, rx_shift_reg[7:1]};
					rx_left_reg <= rx_left_reg - 4'h1;
					rx_cnt_reg <= BIT_CYC - 8'h01;
					rx_done_reg <= rx_left_reg == 4'h1;
				end
			end
		end
	end

	// chain events; a hit in the clearing cycle still sets
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			up_seen_reg <= 1'b0;
			dn_seen_reg <= 1'b0;
		end else begin
			up_seen_reg <= rx_hit_up || (up_seen_reg && group_enable);
			dn_seen_reg <= rx_hit_dn || (dn_seen_reg && !group_enable);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			interdevice_bus_out <= 1'b0;
			interdevice_bus_oe_b <= 1'b1;
			sync_out <= 1'b0;
			sync_out_oe_b <= 1'b1;
			sw_start <= 1'b0;
			rail_on <= 1'b0;
			dev_addr <= 7'h00;
			phase_step <= 4'h0;
			seq_role <= ROLE_DISABLED;
			sync_dir <= SYNC_INPUT;
			seq_active <= 1'b0;
		end else begin
			interdevice_bus_out <= 1'b0;
			interdevice_bus_oe_b <= oe_b_reg;
			sync_out <= sync_out_reg;
			sync_out_oe_b <= sync_oe_b_reg;
			sw_start <= sw_start_reg;
			rail_on <= rail_reg;
			dev_addr <= addr_reg;
			phase_step <= phase_reg;
			seq_role <= role_reg;
			sync_dir <= sdir_reg;
			seq_active <= seq_on;
		end
	end

	chk_bus_low_only: assert property (@(posedge ref_clk) disable iff (!rst_b)
		interdevice_bus_out == 1'b0)
		else $error("interdevice line driven high");
	chk_addr_index_sum: assert property (@(posedge ref_clk) disable iff (!rst_b)
		##1 addr_reg == 7'(10'($past(addr_strap_high)) * 10'h019 + 10'($past(addr_strap_low))))
		else $error("address not 25 times upper plus lower");
	chk_auto_phase: assert property (@(posedge ref_clk) disable iff (!rst_b)
		auto_seq |=> phase_reg == {$past(addr_reg[2:0]), 1'b0})
		else $error("autonomous phase not from address");
	chk_phase_wrap: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(!host_step_ok && addr_reg[2:0] == 3'h0) |=> phase_reg == 4'h0)
		else $error("offset does not wrap at eight addresses");
	chk_host_phase: assert property (@(posedge ref_clk) disable iff (!rst_b)
		host_step_ok |=> phase_reg == $past(host_phase_step[3:0]))
		else $error("host phase step not applied");
	chk_start_slot: assert property (@(posedge ref_clk) disable iff (!rst_b)
		sw_start_reg |-> sw_cnt_reg == $past(phase_at))
		else $error("cycle start not at phase slot");
	chk_wait_pred: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(state_reg == ST_WAIT_UP && seq_on && has_pred && !up_seen_reg && !rx_hit_up && group_enable)
		|=> state_reg == ST_WAIT_UP)
		else $error("powered up before predecessor");
	chk_wait_succ: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(state_reg == ST_WAIT_DN && seq_on && has_succ && !dn_seen_reg && !rx_hit_dn)
		|=> state_reg == ST_WAIT_DN)
		else $error("powered down before successor");
	chk_share_blocks: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(current_share_en && !host_chain_en) |-> !auto_seq)
		else $error("autonomous sequencing on sharing rail");
	chk_enable_start: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(state_reg == ST_OFF && group_enable) |=> state_reg == ST_WAIT_UP)
		else $error("enable did not start turn-on");
	chk_plain_on: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(state_reg == ST_WAIT_UP && group_enable && !seq_on) |=> rail_reg)
		else $error("unsequenced rail did not follow enable");
	chk_frame_start: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(send_up || send_dn) |=> !oe_b_reg [*8])
		else $error("frame start bit too short");

	cov_up_event: cover property (@(posedge ref_clk) disable iff (!rst_b) send_up);
	cov_dn_event: cover property (@(posedge ref_clk) disable iff (!rst_b) send_dn);
	cov_pred_hit: cover property (@(posedge ref_clk) disable iff (!rst_b) rx_hit_up ##1 state_reg == ST_RAMP_UP);
	cov_sync_follow: cover property (@(posedge ref_clk) disable iff (!rst_b) follow_sync && sync_edge);
endmodule

// File: tb/peer_ctrl_model.sv
// peer controller on the shared interdevice line
`timescale 1ns/1ps
`include "seq_phase_map.svh"
module peer_ctrl_model (
	input wire logic ref_clk,
	input wire logic bus_line,
	output logic pull_low,
	output logic [6:0] rx_addr,
	output logic rx_dir,
	output logic [7:0] rx_cnt
);
	logic sending = 1'b0;
	logic [7:0] sh;
	initial begin
		pull_low = 1'b0;
		rx_cnt = 8'h00;
	end
	// lsb-first frame, line only pulled low or released
	task automatic send_frame(input logic [6:0] a, input logic d);
		logic [9:0] fr;
		fr = {1'b1, d, a, 1'b0};
		sending = 1'b1;
		for (int i = 0; i < 10; i++) begin
			@(posedge ref_clk);
			pull_low <= ~fr[i];
			repeat (`BIT_CYC - 1) @(posedge ref_clk);
		end
		@(posedge ref_clk);
		sending = 1'b0;
	endtask
	// own frames are not received
	always begin
		@(posedge ref_clk);
		if (!bus_line && !sending) begin
			repeat (`BIT_CYC * 3 / 2 - 1) @(posedge ref_clk);
			for (int i = 0; i < 8; i++) begin
				sh[i] = bus_line;
				repeat (`BIT_CYC) @(posedge ref_clk);
			end
			rx_addr <= sh[6:0];
			rx_dir <= sh[7];
			rx_cnt <= rx_cnt + 8'h01;
		end
	end
endmodule

// File: tb/seq_phase_spread_tb.sv
// bench for strap decode, phase spreading and bus sequencing
`timescale 1ns/1ps
module seq_phase_spread_tb;
	import seq_phase_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [4:0] lo = 5'h00, hi = 5'h00, hstep = 5'h00;
	logic [3:0] cfg = 4'h0;
	logic share = 1'b0, hen = 1'b0, gen = 1'b0, pg = 1'b0, syi = 1'b0;
	logic hch = 1'b0, hpe = 1'b0, hse = 1'b0;
	logic [6:0] hpa = 7'h00, hsa = 7'h00;
	logic bo, boe_b, pull, line, syo, syo_oe_b, sws, rail, act, rdir;
	logic [6:0] addr, raddr;
	logic [3:0] ph;
	seq_role_t role;
	sync_dir_t sdir;
	logic [7:0] rcnt;
	logic [4:0] hv[5] = '{5'h00, 5'h00, 5'h01, 5'h04, 5'h05};
	logic [4:0] lv[5] = '{5'h00, 5'h18, 5'h0C, 5'h15, 5'h09};
	logic [6:0] av[5] = '{7'h00, 7'h18, 7'h25, 7'h79, 7'h06};
	logic [4:0] sv[4] = '{5'h00, 5'h0F, 5'h10, 5'h11};
	logic [3:0] pv[4] = '{4'h0, 4'hF, 4'h0, 4'h2};
	int err_total = 0, samples_checked = 0, cyc = 0, t0, t1;
	assign line = (boe_b | bo) & ~pull;
	always #12.5 ref_clk = ~ref_clk;
	seq_phase_spread i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .addr_strap_low(lo), .addr_strap_high(hi),
		.cfg_strap(cfg), .current_share_en(share), .host_phase_en(hen), .host_phase_step(hstep),
		.host_chain_en(hch), .host_pred_en(hpe), .host_pred_addr(hpa), .host_succ_en(hse),
		.host_succ_addr(hsa), .group_enable(gen), .power_good(pg), .sync_in(syi),
		.interdevice_bus_in(line), .interdevice_bus_out(bo), .interdevice_bus_oe_b(boe_b),
		.sync_out(syo), .sync_out_oe_b(syo_oe_b), .sw_start(sws), .rail_on(rail), .dev_addr(addr),
		.phase_step(ph), .seq_role(role), .sync_dir(sdir), .seq_active(act));
	peer_ctrl_model i_peer (.ref_clk(ref_clk), .bus_line(line), .pull_low(pull), .rx_addr(raddr),
		.rx_dir(rdir), .rx_cnt(rcnt));
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic straps(input logic [4:0] h, input logic [4:0] l, input logic [3:0] c);
		@(posedge ref_clk);
		hi <= h;
		lo <= l;
		cfg <= c;
		tick(4);
		@(negedge ref_clk);
	endtask
	task automatic wait_sw(output int n);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while ((sws !== 1'b1 || n < 2) && n < 400);
	endtask
	task automatic pulse_sync();
		@(posedge ref_clk);
		syi <= 1'b1;
		@(posedge ref_clk);
		syi <= 1'b0;
	endtask
	task automatic wait_rail(input logic v);
		int n;
		n = 0;
		while (rail !== v && n < 1000) begin
			@(posedge ref_clk);
			n++;
		end
		check("rail_on", {7'h00, v}, {7'h00, rail});
	endtask
	task automatic expect_frame(input logic [6:0] a, input logic d);
		int n;
		logic [7:0] old;
		n = 0;
		old = rcnt;
		while (rcnt === old && n < 1500) begin
			@(posedge ref_clk);
			n++;
		end
		check("frame addr", {1'b0, a}, {1'b0, raddr});
		check("frame dir", {7'h00, d}, {7'h00, rdir});
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			test_done();
		end
	end
	initial begin
		tick(5);
		rst_b <= 1'b1;
		@(negedge ref_clk);
		check("oe_b", 8'h01, {7'h00, boe_b});
		check("rail", 8'h00, {7'h00, rail});
		check("bus_out", 8'h00, {7'h00, bo});
		for (int i = 0; i < 5; i++) begin
			straps(hv[i], lv[i], 4'h0);
			check("dev_addr", {1'b0, av[i]}, {1'b0, addr});
			check("phase", {4'h0, av[i][2:0], 1'b0}, {4'h0, ph});
		end
		@(posedge ref_clk);
		hen <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			hstep <= sv[i];
			straps(5'h00, 5'h01, 4'h0);
			check("host phase", {4'h0, pv[i]}, {4'h0, ph});
		end
		hstep <= 5'h05;
		for (int c = 0; c < 13; c++) begin
			straps(5'h00, 5'h01, c[3:0]);
			check("role", (c < 12) ? 8'(c / 3) : 8'h00, {6'h00, role});
			check("sync_dir", (c < 12) ? 8'(c % 3) : 8'h00, {6'h00, sdir});
			check("sync_oe_b", (c < 12 && c % 3 != 0) ? 8'h00 : 8'h01, {7'h00, syo_oe_b});
			check("active", (c > 2 && c < 12) ? 8'h01 : 8'h00, {7'h00, act});
			check("phase", (c > 2 && c < 12) ? 8'h02 : 8'h05, {4'h0, ph});
		end
		share <= 1'b1;
		straps(5'h00, 5'h01, 4'h3);
		check("active", 8'h00, {7'h00, act});
		share <= 1'b0;
		hen <= 1'b0;
		straps(5'h00, 5'h01, 4'h0);
		pulse_sync();
		wait_sw(t0);
		straps(5'h00, 5'h04, 4'h0);
		pulse_sync();
		wait_sw(t1);
		check("phase delay", 8'h3C, 8'(t1 - t0));
		wait_sw(t1);
		check("period", 8'hA0, 8'(t1));
		tick(79);
		@(negedge ref_clk);
		check("sync_out", 8'h01, {7'h00, syo});
		gen <= 1'b1;
		wait_rail(1'b1);
		@(posedge ref_clk);
		gen <= 1'b0;
		wait_rail(1'b0);
		straps(5'h00, 5'h05, 4'h9);
		gen <= 1'b1;
		tick(200);
		check("rail held", 8'h00, {7'h00, rail});
		i_peer.send_frame(7'h07, 1'b1);
		tick(20);
		check("rail held", 8'h00, {7'h00, rail});
		i_peer.send_frame(7'h04, 1'b1);
		wait_rail(1'b1);
		pg <= 1'b1;
		expect_frame(7'h05, 1'b1);
		gen <= 1'b0;
		tick(200);
		check("rail held", 8'h01, {7'h00, rail});
		i_peer.send_frame(7'h06, 1'b0);
		wait_rail(1'b0);
		pg <= 1'b0;
		expect_frame(7'h05, 1'b0);
		hch <= 1'b1;
		hpe <= 1'b1;
		hpa <= 7'h20;
		hse <= 1'b1;
		hsa <= 7'h30;
		share <= 1'b1;
		hen <= 1'b1;
		hstep <= 5'h03;
		straps(5'h00, 5'h05, 4'h9);
		check("active", 8'h01, {7'h00, act});
		check("phase", 8'h03, {4'h0, ph});
		gen <= 1'b1;
		tick(40);
		check("rail held", 8'h00, {7'h00, rail});
		i_peer.send_frame(7'h20, 1'b1);
		wait_rail(1'b1);
		pg <= 1'b1;
		expect_frame(7'h05, 1'b1);
		gen <= 1'b0;
		tick(40);
		check("rail held", 8'h01, {7'h00, rail});
		i_peer.send_frame(7'h30, 1'b0);
		wait_rail(1'b0);
		pg <= 1'b0;
		expect_frame(7'h05, 1'b0);
		test_done();
	end
endmodule
